/* design/nibble_mem.sv */
// Purpose: nibble-wide working memory with registered read data
// Assumes: one write or one read per cycle, same clock as the bus
// Notes: contents are not reset; read data holds until the next read
`timescale 1ns/1ps
module nibble_mem #(
  parameter int DEPTH = 240,
  parameter int WIDTH = 4,
  parameter int AW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic we,
  input wire logic re,
  input wire logic [AW-1:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rdata_ff;

  // ==========================================================================
  // array: no reset so it maps onto plain storage
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // read register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= '0;
    end else if (re) begin
      rdata_ff <= mem[addr];
    end
  end

  assign rdata = rdata_ff;

endmodule // nibble_mem

/* design/nibble_ram_ctrl.sv */
// Purpose: working registers, nibble RAM, flag groups and control latches
// Assumes: interpreter core is the only APB master; ticks come from same clock
// Notes: zero wait states; unmapped or forbidden accesses answer pslverr
`timescale 1ns/1ps
module nibble_ram_ctrl
  import nibble_ram_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic adc_load,
  input wire logic [31:0] adc_result,
  input wire logic opb_load,
  input wire num_type opb_data,
  input wire logic tick_1hz,
  input wire logic tick_16hz,
  input wire logic long_tick,
  input wire logic short_tick,
  input wire logic sensor_supply,
  input wire logic [3:0] port_in,
  output logic [3:0] port_out,
  output logic [3:0] port_oe,
  output logic [5:0] general_outputs,
  output logic eeprom_clock_out,
  output logic eeprom_power_out,
  output logic [3:0] analog_sel,
  output logic battery_check,
  output logic alu_timer_tick,
  output logic current_source_on,
  output logic [6:0] seg_extra,
  output logic flag_test,
  output num_type first_operand,
  output num_type second_operand
);

  state_type s_ff;
  state_type nxt_s;
  logic wr_en;
  logic setup_rd;
  logic sto_hit;
  logic [3:0] sto_idx;
  logic sto_ok;
  logic ram_hit;
  logic dam_hit;
  logic [7:0] ram_idx;
  logic [7:0] mem_addr;
  logic mem_we;
  logic [3:0] mem_rdata;
  logic [1:0] op_code;
  logic [3:0] op_idx;
  logic latch_ok;
  logic known;
  logic [31:0] rd_data;

  // ==========================================================================
  // address decode
  assign wr_en = psel && penable && pwrite;
  assign setup_rd = psel && !penable && !pwrite;
  assign sto_hit = (paddr >= STORE_BASE_OFS) && (paddr < STORE_END_OFS);
  assign sto_idx = 4'((paddr - STORE_BASE_OFS) >> 3);
  // upper stores reachable only with the expand qualifier set
  assign sto_ok = sto_hit && ((sto_idx < DIRECT_STORES) || s_ff.expand);
  // bank 14 is also reachable through its own short window
  assign dam_hit = (paddr[11:6] == DAM_ALIAS_OFS[11:6]);
  assign ram_idx = dam_hit ? {DAM_BANK, paddr[5:2]} : paddr[9:2];
  assign ram_hit = dam_hit || ((paddr[11:10] == RAM_WIN_SEL) && (paddr[9:2] < 8'(RAM_NIBBLES)));
  assign mem_addr = ram_idx;
  assign mem_we = wr_en && ram_hit;
  assign op_code = pwdata[5:4];
  assign op_idx = pwdata[3:0];
  // latches zero and seven belong to the EEPROM routine only
  assign latch_ok = (op_idx < 4'(NUM_LATCHES)) && (op_idx != 4'(EE_CLK_IDX))
                    && (op_idx != 4'(EE_PWR_IDX));

  nibble_mem #(
    .DEPTH(RAM_NIBBLES),
    .WIDTH(4),
    .AW(8)
  ) u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .we(mem_we),
    .re(setup_rd && ram_hit),
    .addr(mem_addr),
    .wdata(pwdata[3:0]),
    .rdata(mem_rdata)
  );

  // ==========================================================================
  // read mux and error answer; every access completes in its first access cycle
  always_comb begin
    rd_data = '0;
    known = 1'b1;
    if (ram_hit) begin
      rd_data = {28'h0000000, mem_rdata};
    end else if (sto_hit) begin
      known = sto_ok;
      if (sto_ok && paddr[2]) begin
        rd_data = {28'h0000000, s_ff.sto[sto_idx].sign};
      end else if (sto_ok) begin
        rd_data = s_ff.sto[sto_idx].value;
      end
    end else begin
      case (paddr)
        ACC_VAL_OFS: rd_data = s_ff.acc.value;
        ACC_SIGN_OFS: rd_data = {26'h0, s_ff.acc_int, s_ff.acc.sign};
        OPB_VAL_OFS: rd_data = s_ff.opb.value;
        OPB_SIGN_OFS: rd_data = {28'h0000000, s_ff.opb.sign};
        FLAG_GROUP_OFS: rd_data = {31'h0, s_ff.grp_two};
        FLAG_OP_OFS: rd_data = {15'h0, s_ff.test, s_ff.flags[s_ff.grp_two]};
        LATCH_OP_OFS: rd_data = {18'h0, s_ff.latch};
        EEPROM_DRIVE_OFS: rd_data = {30'h0, s_ff.latch[EE_PWR_IDX],
                                     s_ff.latch[EE_CLK_IDX]};
        PORT_OUT_OFS: rd_data = {24'h000000, s_ff.port_s2, s_ff.port_out};
        CTRL_OFS: rd_data = {31'h0, s_ff.expand};
        ALU_DONE_OFS: rd_data = '0;
        default: known = 1'b0;
      endcase
    end
  end

  assign pready = 1'b1;
  assign prdata = rd_data;
  assign pslverr = psel && penable && (!known || (pwrite && (paddr == LATCH_OP_OFS)
                   && !latch_ok));

  // ==========================================================================
  // next state
  always_comb begin
    nxt_s = s_ff;
    // two-flop synchronisers for pins
    nxt_s.port_s1 = port_in;
    nxt_s.port_s2 = s_ff.port_s1;
    nxt_s.supply_s1 = sensor_supply;
    nxt_s.supply_s2 = s_ff.supply_s1;
    if (wr_en && sto_ok) begin
      if (paddr[2]) begin
        nxt_s.sto[sto_idx].sign = pwdata[3:0];
      end else begin
        nxt_s.sto[sto_idx].value = pwdata;
      end
    end
    if (wr_en) begin
      case (paddr)
        ACC_VAL_OFS: nxt_s.acc.value = pwdata;
        ACC_SIGN_OFS: begin
          nxt_s.acc.sign = pwdata[3:0];
          nxt_s.acc_int = pwdata[5:4];
        end
        OPB_VAL_OFS: nxt_s.opb.value = pwdata;
        OPB_SIGN_OFS: nxt_s.opb.sign = pwdata[3:0];
        FLAG_GROUP_OFS: begin
          // group sticks until the other pick arrives
          if (pwdata[1:0] == PICK_ONE) begin
            nxt_s.grp_two = 1'b0;
          end else if (pwdata[1:0] == PICK_TWO) begin
            nxt_s.grp_two = 1'b1;
          end
        end
        FLAG_OP_OFS: begin
          case (op_code)
            OP_SET: nxt_s.flags[s_ff.grp_two][op_idx] = 1'b1;
            OP_CLR: nxt_s.flags[s_ff.grp_two][op_idx] = 1'b0;
            OP_TEST: nxt_s.test = s_ff.flags[s_ff.grp_two][op_idx];
            default: nxt_s.test = s_ff.test;
          endcase
        end
        LATCH_OP_OFS: begin
          if (latch_ok && (op_code == OP_SET)) begin
            nxt_s.latch[op_idx] = 1'b1;
          end else if (latch_ok && (op_code == OP_CLR)) begin
            nxt_s.latch[op_idx] = 1'b0;
          end
        end
        EEPROM_DRIVE_OFS: begin
          nxt_s.latch[EE_CLK_IDX] = pwdata[0];
          nxt_s.latch[EE_PWR_IDX] = pwdata[1];
        end
        PORT_OUT_OFS: nxt_s.port_out = pwdata[3:0];
        CTRL_OFS: nxt_s.expand = pwdata[0];
        ALU_DONE_OFS: begin
          // the divide leaves its remainder in store zero, copied from the second operand register
          if ((pwdata[1:0] == DONE_MUL) || (pwdata[1:0] == DONE_HEXDEC)) begin
            nxt_s.sto[0] = '0;
          end else if (pwdata[1:0] == DONE_DIV) begin
            nxt_s.sto[0] = s_ff.opb;
          end
        end
        default: nxt_s.expand = s_ff.expand;
      endcase
    end
    // hardware loads win over a bus write in the same cycle
    if (adc_load) begin
      nxt_s.acc.value = adc_result;
      nxt_s.acc.sign = SIGN_POS;
    end
    if (opb_load) begin
      nxt_s.opb = opb_data;
    end
    // timer events set their flags, winning over a clear
    if (long_tick) begin
      nxt_s.flags[0][LONG_TIMER_FLAG] = 1'b1;
    end
    if (short_tick) begin
      nxt_s.flags[0][SHORT_TIMER_FLAG] = 1'b1;
    end
    // port buffer follows the pins while the port reads
    if (!s_ff.latch[PORT_DIR_IDX]) begin
      nxt_s.flags[0][15:12] = s_ff.port_s2;
    end
  end

  // ==========================================================================
  // state register; all latches and state fields start at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
      s_ff.latch <= LATCH_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================================================
  // latch-driven pins and internal functions
  assign eeprom_clock_out = s_ff.latch[EE_CLK_IDX];
  assign eeprom_power_out = s_ff.latch[EE_PWR_IDX];
  assign general_outputs = s_ff.latch[6:1];
  assign port_out = s_ff.port_out;
  assign port_oe = {4{s_ff.latch[PORT_DIR_IDX]}};
  // battery check overrides the input select
  assign battery_check = s_ff.latch[MUX_A_IDX];
  always_comb begin
    analog_sel = 4'h0;
    if (!s_ff.latch[MUX_A_IDX]) begin
      // latch ten is the low select bit, latch eleven the high one
      analog_sel[{s_ff.latch[MUX_C_IDX], s_ff.latch[MUX_B_IDX]}] = 1'b1;
    end
  end
  assign alu_timer_tick = s_ff.latch[RATE_IDX] ? tick_16hz : tick_1hz;
  assign current_source_on = s_ff.latch[CSRC_IDX] && s_ff.supply_s2;
  assign seg_extra = s_ff.flags[0][7:1];
  assign flag_test = s_ff.test;
  assign first_operand = s_ff.acc;
  assign second_operand = s_ff.opb;

  // ==========================================================================
  // checks
  latch_set_takes_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == LATCH_OP_OFS && latch_ok && op_code == OP_SET)
    |=> s_ff.latch[$past(op_idx)])
    else $error("latch set did not take effect");

  eeprom_latch_guard_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(eeprom_clock_out) |-> $past(wr_en && paddr == EEPROM_DRIVE_OFS))
    else $error("eeprom clock moved without interpreter write");

  mux_select_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_ff.latch[MUX_A_IDX] |-> analog_sel == 4'h0 && battery_check)
    and (!s_ff.latch[MUX_A_IDX] && s_ff.latch[MUX_B_IDX] && !s_ff.latch[MUX_C_IDX]
    |-> analog_sel == 4'h2))
    else $error("analog select wrong");

  timer_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_ff.latch[RATE_IDX] |-> alu_timer_tick == tick_16hz)
    else $error("timer route wrong");

  // judged against the raw supply pin, two edges back through the synchroniser
  current_source_a: assert property (@(posedge pclk) disable iff (!presetn)
    current_source_on |-> s_ff.latch[CSRC_IDX] && $past(sensor_supply, 2))
    else $error("current source on without latch and supply");

  store_zero_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ALU_DONE_OFS && pwdata[1:0] == DONE_MUL) |=> s_ff.sto[0] == '0)
    else $error("store zero not cleared");

  expand_guard_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && sto_hit && sto_idx >= DIRECT_STORES && !s_ff.expand)
    |-> pslverr ##1 $stable(s_ff.sto))
    else $error("extended store reached without qualifier");

  group_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(s_ff.grp_two) |-> $past(wr_en && paddr == FLAG_GROUP_OFS))
    else $error("flag group changed by itself");

  timer_flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    long_tick |=> s_ff.flags[0][LONG_TIMER_FLAG])
    else $error("long timer flag lost");

  short_flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    short_tick |=> s_ff.flags[0][SHORT_TIMER_FLAG])
    else $error("short timer flag lost");

  port_buffer_a: assert property (@(posedge pclk) disable iff (!presetn)
    !s_ff.latch[PORT_DIR_IDX] |=> s_ff.flags[0][15:12] == $past(s_ff.port_s2))
    else $error("port buffer flags do not follow the pins");

  latch_clear_takes_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == LATCH_OP_OFS && latch_ok && op_code == OP_CLR)
    |=> !s_ff.latch[$past(op_idx)])
    else $error("latch clear did not take effect");

  // a refused latch index must leave the whole bank alone
  locked_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == LATCH_OP_OFS && !latch_ok) |-> pslverr ##1 $stable(s_ff.latch))
    else $error("locked latch changed by software");

  flag_test_result_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == FLAG_OP_OFS && op_code == OP_TEST)
    |=> flag_test == $past(s_ff.flags[s_ff.grp_two][op_idx]))
    else $error("flag test result wrong");

  adc_load_sign_a: assert property (@(posedge pclk) disable iff (!presetn)
    adc_load |=> first_operand.sign == SIGN_POS && first_operand.value == $past(adc_result))
    else $error("adc result not loaded as positive number");

  opb_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    opb_load |=> second_operand == $past(opb_data))
    else $error("second operand load lost");

  divide_remainder_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ALU_DONE_OFS && pwdata[1:0] == DONE_DIV)
    |=> s_ff.sto[0] == $past(s_ff.opb))
    else $error("remainder not left in store zero");

  port_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == LATCH_OP_OFS && op_code == OP_SET && op_idx == 4'(PORT_DIR_IDX))
    |=> port_oe == 4'hF)
    else $error("port did not turn to output");

endmodule // nibble_ram_ctrl

/* design/nibble_ram_pkg.sv */
// Purpose: shared constants and types of the nibble memory and control latch block
// Assumes: APB byte addressing, one 32-bit word per register
// Notes: offsets are byte addresses inside a 4 KiB window
package nibble_ram_pkg;

  // ==========================================================================
  // geometry
  localparam int NUM_BANKS = 15;
  localparam int BANK_NIBBLES = 16;
  localparam int RAM_NIBBLES = NUM_BANKS * BANK_NIBBLES;
  localparam int NORMAL_BANKS = 14;
  localparam logic [3:0] DAM_BANK = 4'hE;
  localparam int NUM_STORES = 12;
  localparam logic [3:0] DIRECT_STORES = 4'h6;
  localparam int NUM_FLAGS = 16;
  localparam int NUM_LATCHES = 14;

  // ==========================================================================
  // register offsets
  localparam logic [11:0] ACC_VAL_OFS = 12'h000;
  localparam logic [11:0] ACC_SIGN_OFS = 12'h004;
  localparam logic [11:0] OPB_VAL_OFS = 12'h008;
  localparam logic [11:0] OPB_SIGN_OFS = 12'h00C;
  localparam logic [11:0] FLAG_GROUP_OFS = 12'h010;
  localparam logic [11:0] FLAG_OP_OFS = 12'h014;
  localparam logic [11:0] LATCH_OP_OFS = 12'h018;
  localparam logic [11:0] EEPROM_DRIVE_OFS = 12'h01C;
  localparam logic [11:0] PORT_OUT_OFS = 12'h020;
  localparam logic [11:0] CTRL_OFS = 12'h024;
  localparam logic [11:0] ALU_DONE_OFS = 12'h028;
  localparam logic [11:0] STORE_BASE_OFS = 12'h040;
  localparam logic [11:0] STORE_END_OFS = 12'h0A0;
  localparam logic [11:0] DAM_ALIAS_OFS = 12'h300;
  localparam logic [1:0] RAM_WIN_SEL = 2'h1;

  // ==========================================================================
  // field positions
  localparam int EE_CLK_IDX = 0;
  localparam int EE_PWR_IDX = 7;
  localparam int PORT_DIR_IDX = 8;
  localparam int MUX_A_IDX = 9;
  localparam int MUX_B_IDX = 10;
  localparam int MUX_C_IDX = 11;
  localparam int RATE_IDX = 12;
  localparam int CSRC_IDX = 13;
  localparam int LONG_TIMER_FLAG = 10;
  localparam int SHORT_TIMER_FLAG = 11;

  // ==========================================================================
  // codes and reset values
  localparam logic [3:0] SIGN_POS = 4'h0;
  localparam logic [3:0] SIGN_NEG = 4'h1;
  localparam logic [1:0] OP_SET = 2'h1;
  localparam logic [1:0] OP_CLR = 2'h2;
  localparam logic [1:0] OP_TEST = 2'h3;
  localparam logic [1:0] DONE_MUL = 2'h1;
  localparam logic [1:0] DONE_HEXDEC = 2'h2;
  localparam logic [1:0] DONE_DIV = 2'h3;
  localparam logic [1:0] PICK_ONE = 2'h1;
  localparam logic [1:0] PICK_TWO = 2'h2;
  localparam logic [13:0] LATCH_RST = 14'h0;

  typedef struct packed {
    logic [3:0] sign;
    logic [31:0] value;
  } num_type;

  typedef struct packed {
    num_type acc;
    logic [1:0] acc_int;
    num_type opb;
    num_type [NUM_STORES-1:0] sto;
    logic grp_two;
    logic [1:0][NUM_FLAGS-1:0] flags;
    logic test;
    logic [NUM_LATCHES-1:0] latch;
    logic [3:0] port_out;
    logic expand;
    logic [3:0] port_s1;
    logic [3:0] port_s2;
    logic supply_s1;
    logic supply_s2;
  } state_type;

endpackage

/* sim/nibble_ram_ctrl_tb.sv */
// Purpose: self-checking bench for the nibble memory and control latch block
// Assumes: zero wait state APB slave, one 200 MHz clock, async active-low reset
// Notes: inputs move by nonblocking assignment at the rising edge only
`timescale 1ns/1ps
module nibble_ram_ctrl_tb
  import nibble_ram_pkg::*;
;
  // ==========================================================================
  // signals
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, adc_result;
  logic adc_load, opb_load, tick_1hz, tick_16hz, long_tick, short_tick, sensor_supply;
  logic eeprom_clock_out, eeprom_power_out, battery_check, alu_timer_tick;
  logic current_source_on, flag_test;
  logic [3:0] port_in, port_out, port_oe, analog_sel;
  logic [5:0] general_outputs;
  logic [6:0] seg_extra;
  num_type opb_data, first_operand, second_operand;
  int n_mismatch, num_checks, cycles;

  nibble_ram_ctrl nibble_ram_ctrl_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_load(adc_load), .adc_result(adc_result), .opb_load(opb_load),
    .opb_data(opb_data), .tick_1hz(tick_1hz), .tick_16hz(tick_16hz),
    .long_tick(long_tick), .short_tick(short_tick), .sensor_supply(sensor_supply),
    .port_in(port_in), .port_out(port_out), .port_oe(port_oe),
    .general_outputs(general_outputs), .eeprom_clock_out(eeprom_clock_out),
    .eeprom_power_out(eeprom_power_out), .analog_sel(analog_sel),
    .battery_check(battery_check), .alu_timer_tick(alu_timer_tick),
    .current_source_on(current_source_on), .seg_extra(seg_extra),
    .flag_test(flag_test), .first_operand(first_operand), .second_operand(second_operand)
  );

  // ==========================================================================
  // clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // the whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // ==========================================================================
  // shared tasks
  task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // one transfer; the request stands until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait count assumed; only the bench timeout ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask

  // set, clear or test one bit of the latch or flag bank
  task automatic bitop(input logic [11:0] a, input logic [1:0] op, input logic [3:0] idx);
    apb(1'b1, a, {26'h0, op, idx});
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    #1;
    chk(general_outputs, 6'h00, "outputs after reset");
    chk({eeprom_power_out, eeprom_clock_out}, 2'h0, "eeprom pins after reset");
    chk(analog_sel, 4'h1, "mux after reset");
    chk(alu_timer_tick, 1'b1, "slow tick routed");
    rdchk(LATCH_OP_OFS, 32'h0, "latches after reset");
    $display("test reset done");
  endtask

  task automatic t_latches();
    logic [5:0] exp;
    logic [3:0] bad [3] = '{4'h0, 4'h7, 4'hE};
    exp = 6'h00;
    for (int i = 1; i <= 6; i++) begin
      bitop(LATCH_OP_OFS, OP_SET, 4'(i));
      exp[i-1] = 1'b1;
      chk(general_outputs, exp, "output latch set");
    end
    bitop(LATCH_OP_OFS, OP_CLR, 4'h3);
    chk(general_outputs, 6'h3B, "output latch clear");
    for (int k = 0; k < 3; k++) begin
      bitop(LATCH_OP_OFS, OP_SET, bad[k]);
      chk(err, 1'b1, "locked latch refused");
    end
    chk({eeprom_power_out, eeprom_clock_out}, 2'h0, "eeprom pins kept");
    rdchk(LATCH_OP_OFS, 32'h76, "latch readback");
    wr(EEPROM_DRIVE_OFS, 32'h3);
    chk({eeprom_power_out, eeprom_clock_out}, 2'h3, "interpreter drive");
    wr(EEPROM_DRIVE_OFS, 32'h0);
    for (int i = 1; i <= 6; i++) begin
      bitop(LATCH_OP_OFS, OP_CLR, 4'(i));
    end
    chk(general_outputs, 6'h00, "outputs cleared");
    $display("test latches done");
  endtask

  // codes are {latch nine, latch ten, latch eleven}
  task automatic t_mux();
    logic [2:0] code [5] = '{3'b000, 3'b010, 3'b001, 3'b011, 3'b111};
    logic [3:0] sel [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0};
    for (int k = 0; k < 5; k++) begin
      for (int j = 0; j < 3; j++) begin
        bitop(LATCH_OP_OFS, code[k][2-j] ? OP_SET : OP_CLR, 4'(9 + j));
      end
      chk(analog_sel, sel[k], "analog input");
      chk(battery_check, k == 4, "battery check");
    end
    for (int j = 9; j <= 11; j++) begin
      bitop(LATCH_OP_OFS, OP_CLR, 4'(j));
    end
    $display("test mux done");
  endtask

  task automatic t_funcs();
    bitop(LATCH_OP_OFS, OP_SET, 4'hC);
    chk(alu_timer_tick, 1'b0, "fast tick routed");
    @(posedge pclk);
    tick_1hz <= 1'b0;
    tick_16hz <= 1'b1;
    #1;
    chk(alu_timer_tick, 1'b1, "fast tick passes");
    bitop(LATCH_OP_OFS, OP_CLR, 4'hC);
    chk(alu_timer_tick, 1'b0, "slow tick back");
    bitop(LATCH_OP_OFS, OP_SET, 4'hD);
    chk(current_source_on, 1'b0, "source off without supply");
    @(posedge pclk);
    sensor_supply <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    chk(current_source_on, 1'b1, "source on");
    bitop(LATCH_OP_OFS, OP_CLR, 4'hD);
    chk(current_source_on, 1'b0, "source off");
    wr(PORT_OUT_OFS, 32'hA);
    chk(port_oe, 4'h0, "port is input");
    rdchk(PORT_OUT_OFS, 32'h5A, "port pins and latch");
    bitop(LATCH_OP_OFS, OP_SET, 4'h8);
    chk({port_oe, port_out}, 8'hFA, "port drives latch");
    bitop(LATCH_OP_OFS, OP_CLR, 4'h8);
    chk(port_oe, 4'h0, "port back to input");
    $display("test functions done");
  endtask

  task automatic t_flags();
    wr(FLAG_GROUP_OFS, {30'h0, PICK_TWO});
    bitop(FLAG_OP_OFS, OP_SET, 4'h3);
    bitop(FLAG_OP_OFS, OP_TEST, 4'h3);
    chk(flag_test, 1'b1, "test set flag");
    rdchk(FLAG_OP_OFS, 32'h0001_0008, "group two flags");
    rdchk(FLAG_GROUP_OFS, 32'h1, "group two active");
    wr(FLAG_GROUP_OFS, {30'h0, PICK_ONE});
    bitop(FLAG_OP_OFS, OP_TEST, 4'h3);
    chk(flag_test, 1'b0, "other group clear");
    bitop(FLAG_OP_OFS, OP_SET, 4'h1);
    chk(seg_extra, 7'h01, "segment flag");
    @(posedge pclk);
    long_tick <= 1'b1;
    short_tick <= 1'b1;
    @(posedge pclk);
    long_tick <= 1'b0;
    short_tick <= 1'b0;
    rdchk(FLAG_OP_OFS, 32'h0000_5C02, "timer and port flags");
    bitop(FLAG_OP_OFS, OP_CLR, 4'h1);
    chk(seg_extra, 7'h00, "segment flag reset");
    wr(FLAG_GROUP_OFS, {30'h0, PICK_TWO});
    rdchk(FLAG_OP_OFS, 32'h8, "group two kept");
    wr(FLAG_GROUP_OFS, {30'h0, PICK_ONE});
    $display("test flags done");
  endtask

  task automatic t_numbers();
    logic [1:0] clr [2] = '{DONE_MUL, DONE_HEXDEC};
    wr(ACC_SIGN_OFS, {28'h0, SIGN_NEG});
    chk(first_operand.sign, SIGN_NEG, "negative sign");
    @(posedge pclk);
    adc_result <= 32'h1234_5678;
    adc_load <= 1'b1;
    @(posedge pclk);
    adc_load <= 1'b0;
    #1;
    chk(first_operand, {SIGN_POS, 32'h1234_5678}, "adc result");
    rdchk(ACC_VAL_OFS, 32'h1234_5678, "accumulator readback");
    @(posedge pclk);
    opb_data <= {SIGN_NEG, 32'h0000_0007};
    opb_load <= 1'b1;
    @(posedge pclk);
    opb_load <= 1'b0;
    #1;
    chk(second_operand, {SIGN_NEG, 32'h0000_0007}, "second operand");
    rdchk(OPB_SIGN_OFS, 32'h1, "second operand sign");
    wr(12'h070, 32'h99);
    chk(err, 1'b1, "extended store refused");
    wr(CTRL_OFS, 32'h1);
    wr(12'h070, 32'h99);
    rdchk(12'h070, 32'h99, "extended store");
    wr(CTRL_OFS, 32'h0);
    wr(12'h068, 32'h42);
    rdchk(12'h068, 32'h42, "direct store");
    wr(STORE_BASE_OFS, 32'h55);
    wr(ALU_DONE_OFS, {30'h0, DONE_DIV});
    rdchk(STORE_BASE_OFS, 32'h7, "remainder");
    rdchk(STORE_BASE_OFS + 12'h004, 32'h1, "remainder sign");
    for (int k = 0; k < 2; k++) begin
      wr(STORE_BASE_OFS, 32'h55);
      wr(ALU_DONE_OFS, {30'h0, clr[k]});
      rdchk(STORE_BASE_OFS, 32'h0, "store zero cleared");
    end
    $display("test numbers done");
  endtask

  task automatic t_ram();
    wr(12'h400, 32'hA);
    wr(12'h7BC, 32'h5);
    rdchk(12'h400, 32'hA, "first nibble");
    rdchk(12'h7BC, 32'h5, "last nibble");
    wr(DAM_ALIAS_OFS + 12'h004, 32'hC);
    rdchk(12'h784, 32'hC, "direct bank alias");
    rdchk(12'h7C0, 32'h0, "beyond memory");
    chk(err, 1'b1, "beyond memory refused");
    $display("test ram done");
  endtask

  // ==========================================================================
  // closing report
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, adc_load, opb_load} = 6'h00;
    {long_tick, short_tick, sensor_supply, tick_16hz} = 4'h0;
    tick_1hz = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    adc_result = 32'h0;
    opb_data = '0;
    port_in = 4'h5;
    n_mismatch = 0;
    num_checks = 0;
    cycles = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_latches();
    t_mux();
    t_funcs();
    t_flags();
    t_numbers();
    t_ram();
    end_of_test();
  end

endmodule // nibble_ram_ctrl_tb
